//--- src/wdtm_pkg.sv
package wdtm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         AXI_AW          = 8;
  localparam logic [7:0] OFF_WATCHDOG_CONTROL_REG       = 8'h00;
  localparam logic [7:0] OFF_CKCON       = 8'h04;
  localparam logic [7:0] OFF_TA          = 8'h08;
  localparam logic [7:0] OFF_IRQ_CTRL    = 8'h0C;
  localparam logic [7:0] OFF_INT_STATUS  = 8'h10;
  localparam logic [7:0] OFF_INT_CLEAR   = 8'h14;
  localparam logic [7:0] OFF_INT_ENABLE  = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RESTART_BIT     = 0;
  localparam int RST_EN_BIT      = 1;
  localparam int RST_FLAG_BIT    = 2;
  localparam int TIMEOUT_BIT     = 3;
  localparam int RUN_BIT         = 4;
  localparam int SEL_LO_BIT      = 6;
  localparam int SEL_HI_BIT      = 7;
  localparam int WD_IE_BIT       = 0;
  localparam int GIE_BIT         = 1;
  localparam int ST_TIMEOUT      = 0;
  localparam int ST_WDRST        = 1;
  localparam int ST_N            = 2;

  // ----------------------------------------------------------------
  // Reset values and keys
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_RST_VAL     = 2'h0;
  localparam logic [1:0] IRQC_RST_VAL    = 2'h0;
  localparam logic [1:0] INT_EN_RST_VAL  = 2'h0;
  localparam logic [7:0] TA_KEY1         = 8'hAA;
  localparam logic [7:0] TA_KEY2         = 8'h55;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ              = 25_000_000;
  localparam int INTERVAL_CLKS_0     = 131072;
  localparam int INTERVAL_CLKS_1     = 1048576;
  localparam int INTERVAL_CLKS_2     = 8388608;
  localparam int INTERVAL_CLKS_3     = 67108864;
  localparam int POST_TIMEOUT_CLKS   = 512;
  localparam int MACHINE_CYCLE_CLKS  = 4;
  localparam int RST_HOLD_MCYCLES    = 2;
  localparam int RST_HOLD_CLKS       = RST_HOLD_MCYCLES * MACHINE_CYCLE_CLKS;

  typedef enum logic [1:0] {
    TA_IDLE = 2'b00,
    TA_HALF = 2'b01,
    TA_OPEN = 2'b10
  } wdtm_ta_t;

endpackage : wdtm_pkg

//--- src/wdtm_irq_bank.sv
`timescale 1ns/100ps
module wdtm_irq_bank
  import wdtm_pkg::*;
#(
  parameter int N = ST_N
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [N-1:0] event_set,
  input  wire logic         clr_we,
  input  wire logic         en_we,
  input  wire logic [N-1:0] wdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] enable,
  output logic              irq
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] enable;
  } wdtm_bank_t;

  wdtm_bank_t s;
  wdtm_bank_t next_s;

  if (N < 1 || N > 32) begin : g_bad_n
    $error("wdtm_irq_bank: N out of range");
  end

  always_comb begin
    next_s = s;
    // Set wins: a clear in the same cycle never hides a new event
    if (clr_we) begin
      next_s.status = s.status & ~wdata;
    end
    next_s.status = next_s.status | event_set;
    if (en_we) begin
      next_s.enable = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.status <= '0;
      s.enable <= N'(INT_EN_RST_VAL);
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign status = s.status;
  assign enable = s.enable;
  assign irq    = |(s.status & s.enable);

endmodule : wdtm_irq_bank

//--- src/wdtm_watchdog.sv
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Watchdog is a free-running system clock counter, interval selectable.
// - Two-bit interval select sits in clock control bits 7 and 6.
// - Codes 00..11 select 2^17, 2^20, 2^23, 2^26 clocks from last restart.
// - Interval elapsed sets timeout flag, control register bit 3.
// - Watchdog interrupt needs its own enable and the global enable.
// - Interrupt and reset functions are independent of each other.
// - Writing one to restart bit clears count; bit reads back zero.
// - Reset system 512 clocks after timeout if enabled and not restarted.
// - Watchdog reset lasts two machine cycles and sets reset flag bit 2.
// - Timeout flag is set every interval even with interrupt and reset off.
// - Power-on or power-fail reset disables the watchdog.
// - Watchdog-caused reset keeps watchdog on, restarts count from zero.
// - Timeout flag is cleared by software write or by any reset.
// - Reset flag cleared by software, power-on or power-fail; kept while reset off.
// - Clearing reset enable stops only the reset; counter keeps running.
// - Reset enable, timeout flag and restart writes need the timed unlock.
module wdtm_watchdog
  import wdtm_pkg::*;
#(
  parameter int unsigned INTERVAL_0 = INTERVAL_CLKS_0,
  parameter int unsigned INTERVAL_1 = INTERVAL_CLKS_1,
  parameter int unsigned INTERVAL_2 = INTERVAL_CLKS_2,
  parameter int unsigned INTERVAL_3 = INTERVAL_CLKS_3,
  parameter int          CNT_W      = 27
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RSTN,
  input  wire logic              CE,
  input  wire logic              PWR_FAIL,
  input  wire logic [AXI_AW-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [AXI_AW-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  output logic                   WDT_IRQ,
  output logic                   IRQ,
  output logic                   WDT_RST
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (INTERVAL_0 <= POST_TIMEOUT_CLKS || INTERVAL_1 <= POST_TIMEOUT_CLKS ||
      INTERVAL_2 <= POST_TIMEOUT_CLKS || INTERVAL_3 <= POST_TIMEOUT_CLKS)
  begin : g_bad_interval
    $error("wdtm_watchdog: interval must exceed post-timeout wait");
  end
  if (CNT_W < 11 || CNT_W > 31 || INTERVAL_3 > (32'd1 << CNT_W))
  begin : g_bad_width
    $error("wdtm_watchdog: counter width cannot hold interval");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_got;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [1:0]        sel;
    logic              run;
    logic              rst_en;
    logic              timeout_flag;
    logic              wd_rst_flag;
    logic              wd_ie;
    logic              gie;
    wdtm_ta_t          ta;
    logic [CNT_W-1:0]  cnt;
    logic              post;
    logic [9:0]        post_cnt;
    logic [3:0]        hold_cnt;
    logic              rst_out;
  } wdtm_state_t;

  localparam logic [9:0] POST_LAST = 10'(POST_TIMEOUT_CLKS - 1);
  localparam logic [3:0] HOLD_LAST = 4'(RST_HOLD_CLKS - 1);

  wdtm_state_t s;
  wdtm_state_t next_s;
  logic        rst_meta;
  logic        rst_n;

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else if (CE) begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode helpers
  // ----------------------------------------------------------------
  logic              do_write;
  logic [7:0]        waddr;
  logic [7:0]        raddr;
  logic              wr_watchdog_control_reg;
  logic              wr_ckcon;
  logic              wr_ta;
  logic              wr_irqc;
  logic              wr_int_clr;
  logic              wr_int_en;
  logic              w_mapped;
  logic              unlocked;
  logic [CNT_W-1:0]  limit;
  logic              timeout_ev;
  logic              fire;
  logic [ST_N-1:0]   st_status;
  logic [ST_N-1:0]   st_enable;
  logic [ST_N-1:0]   st_events;
  logic [7:0]        watchdog_control_reg_rd;

  assign do_write   = s.aw_got && s.w_got && !s.bvalid;
  assign waddr      = 8'({s.aw_addr[AXI_AW-1:2], 2'b00});
  assign raddr      = 8'({ARADDR[AXI_AW-1:2], 2'b00});
  assign wr_watchdog_control_reg   = do_write && s.w_lane0 && waddr == OFF_WATCHDOG_CONTROL_REG;
  assign wr_ckcon   = do_write && s.w_lane0 && waddr == OFF_CKCON;
  assign wr_ta      = do_write && s.w_lane0 && waddr == OFF_TA;
  assign wr_irqc    = do_write && s.w_lane0 && waddr == OFF_IRQ_CTRL;
  assign wr_int_clr = do_write && s.w_lane0 && waddr == OFF_INT_CLEAR;
  assign wr_int_en  = do_write && s.w_lane0 && waddr == OFF_INT_ENABLE;
  assign unlocked   = s.ta == TA_OPEN;

  always_comb begin
    w_mapped = 1'b1;
    if (waddr == OFF_WATCHDOG_CONTROL_REG || waddr == OFF_CKCON || waddr == OFF_TA) begin
      w_mapped = 1'b1;
    end else if (waddr == OFF_IRQ_CTRL || waddr == OFF_INT_CLEAR) begin
      w_mapped = 1'b1;
    end else if (waddr == OFF_INT_ENABLE || waddr == OFF_INT_STATUS) begin
      w_mapped = 1'b1;
    end else begin
      w_mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interval select
  // ----------------------------------------------------------------
  always_comb begin
    case (s.sel)
      2'b00:   limit = CNT_W'(INTERVAL_0 - 1);
      2'b01:   limit = CNT_W'(INTERVAL_1 - 1);
      2'b10:   limit = CNT_W'(INTERVAL_2 - 1);
      default: limit = CNT_W'(INTERVAL_3 - 1);
    endcase
  end

  // Timeout fires whatever the enables say
  assign timeout_ev = s.run && !s.rst_out && s.cnt == limit;
  // Reset only with reset enable; interrupt path is separate
  assign fire = s.post && s.post_cnt == POST_LAST && s.rst_en;
  assign st_events = {fire, timeout_ev};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;

    // AXI write channels, taken in either order
    if (AWVALID && AWREADY) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_s.w_got   = 1'b1;
      next_s.w_data  = WDATA[7:0];
      next_s.w_lane0 = WSTRB[0];
    end
    if (do_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = w_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end

    // AXI read channel
    if (ARVALID && ARREADY) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      if (raddr == OFF_WATCHDOG_CONTROL_REG) begin
        next_s.rdata = {24'h0, watchdog_control_reg_rd};
      end else if (raddr == OFF_CKCON) begin
        next_s.rdata = {24'h0, s.sel, 6'h00};
      end else if (raddr == OFF_IRQ_CTRL) begin
        next_s.rdata = {30'h0, s.gie, s.wd_ie};
      end else if (raddr == OFF_INT_STATUS) begin
        next_s.rdata = 32'(st_status);
      end else if (raddr == OFF_INT_ENABLE) begin
        next_s.rdata = 32'(st_enable);
      end else if (raddr == OFF_TA || raddr == OFF_INT_CLEAR) begin
        next_s.rdata = 32'h0;
      end else begin
        next_s.rdata = 32'h0;
        next_s.rresp = RESP_SLVERR;
      end
    end else if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end

    // Timed access: key pair opens one following register write
    if (wr_ta) begin
      if (s.w_data == TA_KEY1) begin
        next_s.ta = TA_HALF;
      end else if (s.ta == TA_HALF && s.w_data == TA_KEY2) begin
        next_s.ta = TA_OPEN;
      end else begin
        next_s.ta = TA_IDLE;
      end
    end else if (do_write) begin
      next_s.ta = TA_IDLE;
    end

    // Control writes; reset enable and timeout flag clear need the unlock
    if (wr_ckcon) begin
      next_s.sel = {s.w_data[SEL_HI_BIT], s.w_data[SEL_LO_BIT]};
    end
    if (wr_irqc) begin
      next_s.wd_ie = s.w_data[WD_IE_BIT];
      next_s.gie   = s.w_data[GIE_BIT];
    end
    if (wr_watchdog_control_reg && !s.w_data[RST_FLAG_BIT]) begin
      next_s.wd_rst_flag = 1'b0;
    end
    if (wr_watchdog_control_reg && unlocked) begin
      next_s.rst_en = s.w_data[RST_EN_BIT];
      if (!s.w_data[TIMEOUT_BIT]) begin
        next_s.timeout_flag = 1'b0;
      end
    end

    // Free-running divider chain
    if (s.run && !s.rst_out) begin
      next_s.cnt = timeout_ev ? '0 : s.cnt + 1'b1;
    end
    if (timeout_ev) begin
      next_s.timeout_flag = 1'b1;
      next_s.post         = 1'b1;
      next_s.post_cnt     = '0;
    end else if (s.post) begin
      next_s.post_cnt = s.post_cnt + 1'b1;
      if (s.post_cnt == POST_LAST) begin
        next_s.post = 1'b0;
      end
    end

    // Watchdog-caused system reset
    if (fire) begin
      next_s.rst_out      = 1'b1;
      next_s.hold_cnt     = '0;
      next_s.wd_rst_flag  = 1'b1;
      next_s.timeout_flag = 1'b0;
      next_s.cnt          = '0;
    end else if (s.rst_out) begin
      next_s.hold_cnt = s.hold_cnt + 1'b1;
      if (s.hold_cnt == HOLD_LAST) begin
        next_s.rst_out = 1'b0;
      end
    end

    // Restart wins over a timeout in the same cycle
    if (wr_watchdog_control_reg && unlocked && s.w_data[RESTART_BIT]) begin
      next_s.run      = 1'b1;
      next_s.cnt      = '0;
      next_s.post     = 1'b0;
      next_s.post_cnt = '0;
    end

    // Power-fail acts as power-on for the watchdog
    if (PWR_FAIL) begin
      next_s.run          = 1'b0;
      next_s.rst_en       = 1'b0;
      next_s.timeout_flag = 1'b0;
      next_s.wd_rst_flag  = 1'b0;
      next_s.cnt          = '0;
      next_s.post         = 1'b0;
      next_s.post_cnt     = '0;
      next_s.rst_out      = 1'b0;
      next_s.hold_cnt     = '0;
      next_s.sel          = SEL_RST_VAL;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s              <= '0;
      s.bresp        <= RESP_OKAY;
      s.rresp        <= RESP_OKAY;
      s.sel          <= SEL_RST_VAL;
      s.wd_ie        <= IRQC_RST_VAL[WD_IE_BIT];
      s.gie          <= IRQC_RST_VAL[GIE_BIT];
      s.ta           <= TA_IDLE;
      s.run          <= 1'b0;
      s.rst_en       <= 1'b0;
      s.timeout_flag <= 1'b0;
      s.wd_rst_flag  <= 1'b0;
    end else if (CE) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status bank
  // ----------------------------------------------------------------
  wdtm_irq_bank #(
    .N (ST_N)
  ) u_irq_bank (
    .clk       (SYS_CLK),
    .rst_n     (rst_n),
    .ce        (CE),
    .event_set (st_events),
    .clr_we    (wr_int_clr),
    .en_we     (wr_int_en),
    .wdata     (s.w_data[ST_N-1:0]),
    .status    (st_status),
    .enable    (st_enable),
    .irq       (IRQ)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Restart bit is never stored, so it always reads zero
  always_comb begin
    watchdog_control_reg_rd               = 8'h00;
    watchdog_control_reg_rd[RUN_BIT]      = s.run;
    watchdog_control_reg_rd[TIMEOUT_BIT]  = s.timeout_flag;
    watchdog_control_reg_rd[RST_FLAG_BIT] = s.wd_rst_flag;
    watchdog_control_reg_rd[RST_EN_BIT]   = s.rst_en;
  end

  // Readies drop with CE so no beat is taken while state is frozen
  assign AWREADY = CE && rst_n && !s.aw_got && !s.bvalid;
  assign WREADY  = CE && rst_n && !s.w_got && !s.bvalid;
  assign ARREADY = CE && rst_n && !s.rvalid;
  assign BVALID  = s.bvalid;
  assign BRESP   = s.bresp;
  assign RVALID  = s.rvalid;
  assign RDATA   = s.rdata;
  assign RRESP   = s.rresp;
  assign WDT_IRQ = s.timeout_flag && s.wd_ie && s.gie;
  assign WDT_RST = s.rst_out;

endmodule : wdtm_watchdog

//--- verif/wdtm_watchdog_sva.sv
`timescale 1ns/100ps
module wdtm_watchdog_sva
  import wdtm_pkg::*;
#(
  parameter int unsigned INTERVAL_0 = INTERVAL_CLKS_0,
  parameter int unsigned INTERVAL_1 = INTERVAL_CLKS_1,
  parameter int unsigned INTERVAL_2 = INTERVAL_CLKS_2,
  parameter int unsigned INTERVAL_3 = INTERVAL_CLKS_3
) (
  input wire logic        SYS_CLK,
  input wire logic        RSTN,
  input wire logic        CE,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic        WDT_IRQ,
  input wire logic        IRQ,
  input wire logic        WDT_RST
);
  // ----------------------------------------------------------------
  // Gap since last system reset pulse
  // ----------------------------------------------------------------
  localparam int unsigned M01 = INTERVAL_0 < INTERVAL_1 ? INTERVAL_0 : INTERVAL_1;
  localparam int unsigned M23 = INTERVAL_2 < INTERVAL_3 ? INTERVAL_2 : INTERVAL_3;
  localparam int unsigned MIN_IV = M01 < M23 ? M01 : M23;
  logic [31:0] gap;

  // Saturates so a long idle run never wraps into a false short gap
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      gap <= 32'hFFFF_FFFF;
    end else if (WDT_RST) begin
      gap <= 32'h0;
    end else if (gap != 32'hFFFF_FFFF) begin
      gap <= gap + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  a_rst_eight: assert property ($rose(WDT_RST) |-> WDT_RST[*8] ##1 !WDT_RST)
    else $error("system reset pulse not eight clocks");
  a_rst_gap: assert property ($rose(WDT_RST) |-> gap >= MIN_IV + 500)
    else $error("system reset too soon after previous one");
  a_quiet_start: assert property ($rose(RSTN) |-> !WDT_RST && !WDT_IRQ && !IRQ)
    else $error("outputs active at reset release");
  a_b_after: assert property (AWVALID && AWREADY && WVALID && WREADY
    |-> ##2 BVALID)
    else $error("write response late");
  a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_r_after: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read response late");
  a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_w_block: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  a_ar_block: assert property (RVALID |-> !ARREADY)
    else $error("read taken while data pending");
  a_ce_freeze: assert property (!CE |-> !AWREADY && !WREADY && !ARREADY)
    else $error("ready while clock enable low");
  a_err_zero: assert property (RVALID && RRESP == RESP_SLVERR |-> RDATA == 32'h0)
    else $error("error read returned data");

  c_rst: cover property ($rose(WDT_RST));
  c_wirq: cover property ($rose(WDT_IRQ));
  c_err: cover property (RVALID && RRESP == RESP_SLVERR);
endmodule : wdtm_watchdog_sva

bind wdtm_watchdog wdtm_watchdog_sva #(
  .INTERVAL_0(INTERVAL_0), .INTERVAL_1(INTERVAL_1),
  .INTERVAL_2(INTERVAL_2), .INTERVAL_3(INTERVAL_3)
) i_wdtm_watchdog_sva (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
  .WDT_IRQ(WDT_IRQ), .IRQ(IRQ), .WDT_RST(WDT_RST)
);

//--- verif/wdtm_watchdog_bench.sv
`timescale 1ns/100ps
module wdtm_watchdog_bench;
  import wdtm_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and model state
  // ----------------------------------------------------------------
  // Short intervals keep the run small; all stay above the 512 window
  localparam int IV [4] = '{600, 700, 800, 1000};
  logic SYS_CLK = 0, RSTN = 0, CE = 1, PWR_FAIL = 0;
  logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [AXI_AW-1:0] AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0, RDATA, rd;
  logic [3:0]  WSTRB = 4'hF;
  logic [1:0]  BRESP, RRESP, rs;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WDT_IRQ, IRQ, WDT_RST;
  logic [15:0] lf = 16'h0004;
  logic m_run = 0, m_rsten = 0, m_wrf = 0, m_tof = 0;
  int num_errors = 0, samples_checked = 0, cyc = 0, tb, t0, t1, t2, n;

  wdtm_watchdog #(.INTERVAL_0(IV[0]), .INTERVAL_1(IV[1]),
    .INTERVAL_2(IV[2]), .INTERVAL_3(IV[3])) i_wdtm_watchdog (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE), .PWR_FAIL(PWR_FAIL),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .WDT_IRQ(WDT_IRQ), .IRQ(IRQ), .WDT_RST(WDT_RST));

  always #20 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) cyc <= cyc + 1;

  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function logic [31:0] mw();
    return {27'h0, m_run, m_tof, m_wrf, m_rsten, 1'b0};
  endfunction : mw

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task summarize;
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task chkw(input string nm, input int lo, input int hi, input int v);
    samples_checked++;
    if (v < lo || v > hi) begin
      num_errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask : chkw

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic a1, w1, g, got;
    int k;
    got = 0;
    lf = lfsr(lf);
    @(posedge SYS_CLK);
    AWADDR <= a;
    AWVALID <= 1;
    WDATA <= {lf, 8'h00, d};
    WVALID <= 1;
    BREADY <= 1;
    for (k = 0; k < 50 && !got; k++) begin
      @(negedge SYS_CLK);
      a1 = AWVALID && AWREADY;
      w1 = WVALID && WREADY;
      g = BVALID;
      if (g) begin
        rs = BRESP;
        tb = cyc;
      end
      @(posedge SYS_CLK);
      if (a1) AWVALID <= 0;
      if (w1) WVALID <= 0;
      if (g) begin
        BREADY <= 0;
        got = 1;
      end
    end
    if (!got) begin
      chk("bvalid", 1, 0);
      summarize();
    end
  endtask : wr

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er = RESP_OKAY);
    logic a1, g, got;
    int k;
    got = 0;
    lf = lfsr(lf);
    @(posedge SYS_CLK);
    // Low address bits must be ignored, so they carry noise
    ARADDR <= a | {6'h0, lf[1:0]};
    ARVALID <= 1;
    RREADY <= 1;
    for (k = 0; k < 50 && !got; k++) begin
      @(negedge SYS_CLK);
      a1 = ARVALID && ARREADY;
      g = RVALID;
      if (g) begin
        rd = RDATA;
        rs = RRESP;
      end
      @(posedge SYS_CLK);
      if (a1) ARVALID <= 0;
      if (g) begin
        RREADY <= 0;
        got = 1;
      end
    end
    if (!got) begin
      chk("rvalid", 1, 0);
      summarize();
    end
    chk(nm, e, rd);
    chk("rresp", {30'h0, er}, {30'h0, rs});
  endtask : rchk

  task unl;
    wr(OFF_TA, TA_KEY1);
    wr(OFF_TA, TA_KEY2);
  endtask : unl

  task clr(input logic [7:0] w);
    unl();
    wr(OFF_WATCHDOG_CONTROL_REG, w);
    m_rsten = w[1];
    m_tof = 0;
    if (!w[2]) m_wrf = 0;
    wr(OFF_INT_CLEAR, 8'h03);
  endtask : clr

  task wait_hi(input bit sel, input int lim, output int t);
    logic hit;
    int k;
    hit = 0;
    for (k = 0; k < lim && !hit; k++) begin
      @(negedge SYS_CLK);
      hit = sel ? (WDT_RST === 1'b1) : (IRQ === 1'b1);
    end
    t = cyc;
    if (!hit) begin
      chk(sel ? "wdt_rst" : "irq", 1, 0);
      summarize();
    end
  endtask : wait_hi

  task quiet(input int lim);
    logic bad;
    int k;
    bad = 0;
    for (k = 0; k < lim; k++) begin
      @(negedge SYS_CLK);
      if (WDT_RST !== 1'b0) bad = 1;
    end
    chk("wdt_rst quiet", 0, {31'h0, bad});
  endtask : quiet

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RSTN <= 1;
    repeat (3) @(posedge SYS_CLK);
    rchk("watchdog_control_reg", OFF_WATCHDOG_CONTROL_REG, mw());
    rchk("ckcon", OFF_CKCON, 32'h0);
    rchk("irq_ctrl", OFF_IRQ_CTRL, 32'h0);
    rchk("unmapped", 8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h1C, 8'hFF);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(OFF_WATCHDOG_CONTROL_REG, 8'h03);
    rchk("watchdog_control_reg locked", OFF_WATCHDOG_CONTROL_REG, mw());
    wr(OFF_INT_ENABLE, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_IRQ_CTRL, s[7:0]);
      wr(OFF_CKCON, {s[1:0], 6'h00});
      unl();
      wr(OFF_WATCHDOG_CONTROL_REG, 8'h01);
      m_run = 1;
      t0 = tb;
      wait_hi(0, IV[s] + 50, t1);
      chkw("interval", IV[s] - 1, IV[s] + 2, t1 - t0);
      m_tof = 1;
      rchk("watchdog_control_reg timeout", OFF_WATCHDOG_CONTROL_REG, mw());
      chk("wdt_irq", {31'h0, s == 3}, {31'h0, WDT_IRQ});
      clr(8'h00);
      @(negedge SYS_CLK);
      chk("wdt_irq clear", 0, {31'h0, WDT_IRQ});
      chk("irq clear", 0, {31'h0, IRQ});
      if (s == 0) begin
        wait_hi(0, IV[0] + 50, t1);
        chkw("repeat", 2 * IV[0] - 1, 2 * IV[0] + 2, t1 - t0);
        clr(8'h00);
      end
    end
    wr(OFF_IRQ_CTRL, 8'h03);
    wr(OFF_CKCON, 8'h00);
    unl();
    wr(OFF_WATCHDOG_CONTROL_REG, 8'h03);
    m_rsten = 1;
    t0 = tb;
    wait_hi(0, IV[0] + 50, t1);
    chk("wdt_irq both", 1, {31'h0, WDT_IRQ});
    wait_hi(1, 600, t2);
    chkw("reset delay", IV[0] + 511, IV[0] + 514, t2 - t0);
    n = 1;
    for (int k = 0; k < 20 && WDT_RST === 1'b1; k++) begin
      @(negedge SYS_CLK);
      if (WDT_RST === 1'b1) n++;
    end
    t2 = cyc;
    chk("reset width", RST_HOLD_CLKS, n);
    m_wrf = 1;
    m_tof = 0;
    rchk("watchdog_control_reg after reset", OFF_WATCHDOG_CONTROL_REG, mw());
    rchk("int_status", OFF_INT_STATUS, 32'h3);
    chk("wdt_irq after reset", 0, {31'h0, WDT_IRQ});
    wr(OFF_INT_CLEAR, 8'h03);
    wait_hi(0, IV[0] + 50, t1);
    chkw("count from zero", IV[0] - 3, IV[0] + 3, t1 - t2);
    unl();
    wr(OFF_WATCHDOG_CONTROL_REG, 8'h07);
    quiet(560);
    wr(OFF_WATCHDOG_CONTROL_REG, 8'h00);
    m_wrf = 0;
    rchk("watchdog_control_reg flag clear", OFF_WATCHDOG_CONTROL_REG, mw());
    clr(8'h00);
    wait_hi(0, 1300, t1);
    quiet(600);
    m_tof = 1;
    rchk("watchdog_control_reg running", OFF_WATCHDOG_CONTROL_REG, mw());
    wr(OFF_CKCON, 8'h80);
    @(posedge SYS_CLK);
    PWR_FAIL <= 1;
    repeat (2) @(posedge SYS_CLK);
    PWR_FAIL <= 0;
    {m_run, m_rsten, m_wrf, m_tof} = 4'h0;
    rchk("watchdog_control_reg power fail", OFF_WATCHDOG_CONTROL_REG, mw());
    rchk("ckcon power fail", OFF_CKCON, 32'h0);
    CE <= 0;
    @(negedge SYS_CLK);
    chk("arready ce low", 0, {31'h0, ARREADY});
    @(posedge SYS_CLK);
    CE <= 1;
    summarize();
  end
endmodule : wdtm_watchdog_bench
